// ==== core/fiwb_ctrl.sv ====
// flash in-application programming controller with write buffer
// assumes an Avalon-MM master on clk and a flash array answering on clk
// assumes the master holds each request until it sees waitrequest low
// assumes the flash array acks every request exactly once, one cycle high
// limitation: only byte lane zero of the bus carries register data
// limitation: one request per two cycles at best, answer always registered
// trade-off: stall is shown twice, on cpu_stall and as a held waitrequest,
// so a master that ignores the stall line still cannot slip a request in
//
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "fiwb_regs.svh"
module fiwb_ctrl #(
  parameter int UNLOCK_CYCLES = `FIWB_UNLOCK_TIME_US * `FIWB_CLK_MHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register bus
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // processor stall
  output logic cpu_stall,
  // flash array
  output logic fl_req,
  output fiwb_pkg::fiwb_flop_t fl_op,
  output logic [13:0] fl_addr,
  output logic [15:0] fl_wdata,
  input wire logic fl_ack,
  input wire logic [15:0] fl_rdata
);
  fiwb_pkg::fiwb_ctl_t q;
  fiwb_pkg::fiwb_ctl_t next_q;
  fiwb_wbuf_if wb ();
  logic trigger;
  logic unl_success;
  logic unl_start;
  logic unl_match;

  // register readback, reserved bits read as zero
  // trigger comes live from the unlock timer so a timeout shows at once
  // unmapped offsets fall to the default arm and answer zero
  function automatic logic [7:0] reg_read(input fiwb_pkg::fiwb_ctl_t s, input logic [5:0] a,
                                          input logic trig);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `FIWB_OFS_CTRL: v = {s.enabled, s.mode, trig, s.wstart, s.rden, s.rstart};
      `FIWB_OFS_BUFCTL: v = {7'h00, s.bufclr};
      `FIWB_OFS_ADDR_LO: v = s.addr[7:0];
      `FIWB_OFS_ADDR_HI: v = {2'h0, s.addr[13:8]};
      `FIWB_OFS_D0_LO: v = s.data[0][7:0];
      `FIWB_OFS_D0_HI: v = s.data[0][15:8];
      `FIWB_OFS_D1_LO: v = s.data[1][7:0];
      `FIWB_OFS_D1_HI: v = s.data[1][15:8];
      `FIWB_OFS_D2_LO: v = s.data[2][7:0];
      `FIWB_OFS_D2_HI: v = s.data[2][15:8];
      `FIWB_OFS_D3_LO: v = s.data[3][7:0];
      `FIWB_OFS_D3_HI: v = s.data[3][15:8];
      default: v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  // one-cycle write strobe for a given offset, committed at the acked edge
  // committing at the acked edge keeps a held request from writing twice
  function automatic logic wr_hit(input logic ack, input logic wr, input logic be,
                                  input logic [5:0] a, input logic [5:0] ofs);
    return ack && wr && be && (a == ofs);
  endfunction : wr_hit

  fiwb_wbuf u_wbuf (
    .clk(clk),
    .srst(srst),
    .wb(wb.store)
  );

  fiwb_unlock #(
    .CYCLES(UNLOCK_CYCLES)
  ) u_unlock (
    .clk(clk),
    .srst(srst),
    .start(unl_start),
    .match(unl_match),
    .trigger(trigger),
    .success(unl_success)
  );

  // buffer link driven from state
  // registered load keeps the buffer write one cycle behind the bus commit,
  // so the address increment and the buffer word always agree
  assign wb.load = q.load;
  assign wb.load_idx = q.load_idx;
  assign wb.load_data = q.load_data;
  assign wb.rd_idx = q.idx;
  assign wb.clr_start = q.clr_start;

  // outputs straight from state
  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.waitreq;
  assign cpu_stall = q.stall;
  assign fl_req = q.fl_req;
  assign fl_op = q.fl_op;
  assign fl_addr = q.fl_addr;
  assign fl_wdata = q.fl_wdata;

  // unlock patterns checked while the unlock mode stays selected
  // patterns written before the trigger still count, checked every cycle
  // leaving the unlock mode while armed lets the window run out unmatched
  assign unl_match = (q.mode == `FIWB_MODE_UNLOCK) && (q.data[1] == `FIWB_UNLOCK_PAT1) &&
                     (q.data[2] == `FIWB_UNLOCK_PAT2) && (q.data[3] == `FIWB_UNLOCK_PAT3);
  assign unl_start = wr_hit(q.ack, avs_write, avs_byteenable[0], avs_address, `FIWB_OFS_CTRL)
                     && avs_writedata[`FIWB_BIT_TRIGGER]
                     && (avs_writedata[`FIWB_BIT_MODE_HI:`FIWB_BIT_MODE_LO]
                         == `FIWB_MODE_UNLOCK);

  // bus slave, register writes and the operation sequencer
  always_comb begin
    logic [7:0] wd;
    logic [2:0] wmode;
    logic be0;
    logic go_write;
    logic go_read;
    wd = avs_writedata[7:0];
    wmode = wd[`FIWB_BIT_MODE_HI:`FIWB_BIT_MODE_LO];
    be0 = avs_byteenable[0];
    go_write = 1'b0;
    go_read = 1'b0;
    next_q = q;
    next_q.load = 1'b0;
    next_q.clr_start = 1'b0;

    // accept at most one request per two idle cycles; a busy sequencer holds the master
    next_q.ack = (avs_read || avs_write) && !q.ack && (q.state == fiwb_pkg::ST_IDLE);
    next_q.waitreq = !next_q.ack;
    if (next_q.ack && avs_read) begin
      next_q.rdata = {24'h000000, reg_read(q, avs_address, trigger)};
    end

    // control register
    if (wr_hit(q.ack, avs_write, be0, avs_address, `FIWB_OFS_CTRL)) begin
      next_q.mode = wmode;
      next_q.rden = wd[`FIWB_BIT_RDEN];
      if (!wd[`FIWB_BIT_ENABLED]) begin
        next_q.enabled = 1'b0;
      end
      // start bits set together are refused, as firmware may not combine them
      if (wd[`FIWB_BIT_WSTART] && !wd[`FIWB_BIT_RSTART] && q.enabled &&
          (wmode == `FIWB_MODE_WRITE || wmode == `FIWB_MODE_ERASE)) begin
        go_write = 1'b1;
      end else if (wd[`FIWB_BIT_RSTART] && !wd[`FIWB_BIT_WSTART] && q.rden &&
                   wd[`FIWB_BIT_RDEN] && wmode == `FIWB_MODE_READ) begin
        go_read = 1'b1;
      end
    end
    // hardware set wins over a software clear in the same cycle
    if (unl_success) begin
      next_q.enabled = 1'b1;
    end

    // buffer clear register
    if (wr_hit(q.ack, avs_write, be0, avs_address, `FIWB_OFS_BUFCTL) &&
        wd[`FIWB_BIT_BUFCLR] && !q.bufclr) begin
      next_q.bufclr = 1'b1;
      next_q.clr_start = 1'b1;
    end
    if (wb.clr_done && q.state == fiwb_pkg::ST_IDLE) begin
      next_q.bufclr = 1'b0;
    end

    // address pointer
    if (wr_hit(q.ack, avs_write, be0, avs_address, `FIWB_OFS_ADDR_LO)) begin
      next_q.addr[7:0] = wd;
    end
    if (wr_hit(q.ack, avs_write, be0, avs_address, `FIWB_OFS_ADDR_HI)) begin
      next_q.addr[13:8] = wd[5:0];
    end

    // data pairs; the high byte of pair zero also feeds the buffer
    if (wr_hit(q.ack, avs_write, be0, avs_address, `FIWB_OFS_D0_LO)) begin
      next_q.data[0][7:0] = wd;
    end
    if (wr_hit(q.ack, avs_write, be0, avs_address, `FIWB_OFS_D0_HI)) begin
      next_q.data[0][15:8] = wd;
      if (q.enabled && !q.bufclr) begin
        next_q.load = 1'b1;
        next_q.load_idx = q.addr[5:0];
        next_q.load_data = {wd, q.data[0][7:0]};
        if (q.addr[5:0] != `FIWB_WB_LAST) begin
          next_q.addr = q.addr + 14'h0001;
        end
      end
    end
    if (wr_hit(q.ack, avs_write, be0, avs_address, `FIWB_OFS_D1_LO)) begin
      next_q.data[1][7:0] = wd;
    end
    if (wr_hit(q.ack, avs_write, be0, avs_address, `FIWB_OFS_D1_HI)) begin
      next_q.data[1][15:8] = wd;
    end
    if (wr_hit(q.ack, avs_write, be0, avs_address, `FIWB_OFS_D2_LO)) begin
      next_q.data[2][7:0] = wd;
    end
    if (wr_hit(q.ack, avs_write, be0, avs_address, `FIWB_OFS_D2_HI)) begin
      next_q.data[2][15:8] = wd;
    end
    if (wr_hit(q.ack, avs_write, be0, avs_address, `FIWB_OFS_D3_LO)) begin
      next_q.data[3][7:0] = wd;
    end
    if (wr_hit(q.ack, avs_write, be0, avs_address, `FIWB_OFS_D3_HI)) begin
      next_q.data[3][15:8] = wd;
    end

    // sequencer
    // idle: a start bit accepted at the acked edge picks the operation
    // prog issue/wait: one flash word per pair, idx walks 0 to 63
    // prog clr: buffer blanks itself before write-start drops
    // erase wait and read wait: a single flash handshake each
    // hazard: the bus stays held in every non-idle state, so no register
    // write can change the address or mode under a running operation
    unique case (q.state)
      fiwb_pkg::ST_IDLE: begin
        if (go_write && wmode == `FIWB_MODE_ERASE) begin
          next_q.wstart = 1'b1;
          next_q.fl_req = 1'b1;
          next_q.fl_op = fiwb_pkg::FL_ERASE;
          next_q.fl_addr = {q.addr[13:6], 6'h00};
          next_q.state = fiwb_pkg::ST_ERASE_WAIT;
        end else if (go_write) begin
          next_q.wstart = 1'b1;
          next_q.idx = 6'h00;
          next_q.state = fiwb_pkg::ST_PROG_ISSUE;
        end else if (go_read) begin
          next_q.rstart = 1'b1;
          next_q.fl_req = 1'b1;
          next_q.fl_op = fiwb_pkg::FL_READ;
          next_q.fl_addr = q.addr;
          next_q.state = fiwb_pkg::ST_READ_WAIT;
        end
      end
      // buffer word for idx is read combinationally and registered here
      fiwb_pkg::ST_PROG_ISSUE: begin
        next_q.fl_req = 1'b1;
        next_q.fl_op = fiwb_pkg::FL_PROG;
        next_q.fl_addr = {q.addr[13:6], q.idx};
        next_q.fl_wdata = wb.rd_data;
        next_q.state = fiwb_pkg::ST_PROG_WAIT;
      end
      // request held until the array acks, then next word or buffer clear
      fiwb_pkg::ST_PROG_WAIT: begin
        if (fl_ack) begin
          next_q.fl_req = 1'b0;
          if (q.idx == `FIWB_WB_LAST) begin
            next_q.clr_start = 1'b1;
            next_q.state = fiwb_pkg::ST_PROG_CLR;
          end else begin
            next_q.idx = q.idx + 6'h01;
            next_q.state = fiwb_pkg::ST_PROG_ISSUE;
          end
        end
      end
      // write-start stays high until the blank walk has finished
      fiwb_pkg::ST_PROG_CLR: begin
        if (wb.clr_done) begin
          next_q.wstart = 1'b0;
          next_q.state = fiwb_pkg::ST_IDLE;
        end
      end
      // whole page blanked by the array in one handshake
      fiwb_pkg::ST_ERASE_WAIT: begin
        if (fl_ack) begin
          next_q.fl_req = 1'b0;
          next_q.wstart = 1'b0;
          next_q.state = fiwb_pkg::ST_IDLE;
        end
      end
      // read word taken at the acked edge, never from a stale cycle
      fiwb_pkg::ST_READ_WAIT: begin
        if (fl_ack) begin
          next_q.fl_req = 1'b0;
          next_q.data[0] = fl_rdata;
          next_q.rstart = 1'b0;
          next_q.state = fiwb_pkg::ST_IDLE;
        end
      end
    endcase
    next_q.stall = (next_q.state != fiwb_pkg::ST_IDLE);
  end

  // state register
  // reset clears every field, then names the fields whose reset value
  // matters; waitrequest starts high so no request is taken in reset
  // the write buffer keeps its own reset to blank words
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.state <= fiwb_pkg::ST_IDLE;
      q.mode <= `FIWB_RST_MODE;
      q.addr <= `FIWB_RST_ADDR;
      q.data <= {4{`FIWB_RST_DATA}};
      q.waitreq <= 1'b1;
      q.fl_op <= fiwb_pkg::FL_READ;
    end else begin
      q <= next_q;
    end
  end
endmodule : fiwb_ctrl

// ==== core/fiwb_pkg.sv ====
// types shared by the flash write-buffer controller modules
// assumes fiwb_regs.svh carries all numeric constants
package fiwb_pkg;

  // operation requested from the flash array
  typedef enum logic [1:0] {FL_READ, FL_ERASE, FL_PROG} fiwb_flop_t;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_PROG_ISSUE, ST_PROG_WAIT, ST_PROG_CLR, ST_ERASE_WAIT, ST_READ_WAIT
  } fiwb_state_t;

  // write buffer state
  typedef struct packed {
    logic [63:0][15:0] mem;
    logic clr_busy;
    logic [5:0] clr_idx;
    logic clr_done;
  } fiwb_wb_t;

  // unlock timer state
  typedef struct packed {
    logic armed;
    logic [15:0] count;
    logic success;
  } fiwb_unl_t;

  // controller state
  typedef struct packed {
    fiwb_state_t state;
    logic enabled;
    logic [2:0] mode;
    logic wstart;
    logic rden;
    logic rstart;
    logic bufclr;
    logic [13:0] addr;
    logic [3:0][15:0] data;
    logic [5:0] idx;
    logic ack;
    logic waitreq;
    logic [31:0] rdata;
    logic stall;
    logic fl_req;
    fiwb_flop_t fl_op;
    logic [13:0] fl_addr;
    logic [15:0] fl_wdata;
    logic clr_start;
    logic load;
    logic [5:0] load_idx;
    logic [15:0] load_data;
  } fiwb_ctl_t;

endpackage : fiwb_pkg

// ==== core/fiwb_regs.svh ====
// register map, field positions, reset values and timing counts of the
// flash write-buffer controller; included by the controller and write-buffer modules and the bench by bare name
`ifndef FIWB_REGS_SVH
`define FIWB_REGS_SVH

// byte offsets on the register bus, one aligned word each
`define FIWB_OFS_CTRL 6'h00
`define FIWB_OFS_BUFCTL 6'h08
`define FIWB_OFS_ADDR_LO 6'h0C
`define FIWB_OFS_ADDR_HI 6'h10
`define FIWB_OFS_D0_LO 6'h14
`define FIWB_OFS_D0_HI 6'h18
`define FIWB_OFS_D1_LO 6'h1C
`define FIWB_OFS_D1_HI 6'h20
`define FIWB_OFS_D2_LO 6'h24
`define FIWB_OFS_D2_HI 6'h28
`define FIWB_OFS_D3_LO 6'h2C
`define FIWB_OFS_D3_HI 6'h30

// control and buffer clear register fields
`define FIWB_BIT_ENABLED 7
`define FIWB_BIT_MODE_HI 6
`define FIWB_BIT_MODE_LO 4
`define FIWB_BIT_TRIGGER 3
`define FIWB_BIT_WSTART 2
`define FIWB_BIT_RDEN 1
`define FIWB_BIT_RSTART 0
`define FIWB_BIT_BUFCLR 0

// operation mode codes
`define FIWB_MODE_WRITE 3'h0
`define FIWB_MODE_ERASE 3'h1
`define FIWB_MODE_READ 3'h3
`define FIWB_MODE_UNLOCK 3'h6

// reset values
`define FIWB_RST_MODE 3'h0
`define FIWB_RST_ADDR 14'h0000
`define FIWB_RST_DATA 16'h0000

// unlock patterns for data pairs one to three
`define FIWB_UNLOCK_PAT1 16'h1234
`define FIWB_UNLOCK_PAT2 16'h5678
`define FIWB_UNLOCK_PAT3 16'h9ABC

// buffer geometry and blank word
`define FIWB_WB_LAST 6'h3F
`define FIWB_WB_BLANK 16'hFFFF

// unlock window and clock rate
`define FIWB_UNLOCK_TIME_US 1000
`define FIWB_CLK_MHZ 10

`endif

// ==== core/fiwb_unlock.sv ====
// erase/write unlock window timer
// assumes match is a level computed on the same clock
`timescale 1ns/1ps
module fiwb_unlock #(
  parameter int CYCLES = 10000
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic start,
  input wire logic match,
  // status
  output logic trigger,
  output logic success
);
  fiwb_pkg::fiwb_unl_t q;
  fiwb_pkg::fiwb_unl_t next_q;

  assign trigger = q.armed;
  assign success = q.success;

  // window closes on the right patterns or on timeout, whichever first
  always_comb begin
    next_q = q;
    next_q.success = 1'b0;
    if (start) begin
      next_q.armed = 1'b1;
      next_q.count = 16'(CYCLES - 1);
    end else if (q.armed) begin
      if (match) begin
        next_q.armed = 1'b0;
        next_q.success = 1'b1;
      end else if (q.count == 16'h0000) begin
        next_q.armed = 1'b0;
      end else begin
        next_q.count = q.count - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '{armed: 1'b0, count: 16'h0000, success: 1'b0};
    end else begin
      q <= next_q;
    end
  end
endmodule : fiwb_unlock

// ==== core/fiwb_wbuf.sv ====
// 64-word write buffer with a walking clear
// assumes the controller never asks for a clear while one runs
`timescale 1ns/1ps
`include "fiwb_regs.svh"
module fiwb_wbuf (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // controller side
  fiwb_wbuf_if.store wb
);
  fiwb_pkg::fiwb_wb_t q;
  fiwb_pkg::fiwb_wb_t next_q;

  // read port is combinational so the controller can latch it in one cycle
  assign wb.rd_data = q.mem[wb.rd_idx];
  assign wb.clr_done = q.clr_done;

  // clear walks one word per cycle; loads are dropped while it runs
  always_comb begin
    next_q = q;
    next_q.clr_done = 1'b0;
    if (q.clr_busy) begin
      next_q.mem[q.clr_idx] = `FIWB_WB_BLANK;
      next_q.clr_idx = q.clr_idx + 6'h01;
      if (q.clr_idx == `FIWB_WB_LAST) begin
        next_q.clr_busy = 1'b0;
        next_q.clr_done = 1'b1;
      end
    end else if (wb.clr_start) begin
      next_q.clr_busy = 1'b1;
      next_q.clr_idx = 6'h00;
    end else if (wb.load) begin
      next_q.mem[wb.load_idx] = wb.load_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '{mem: {64{`FIWB_WB_BLANK}}, clr_busy: 1'b0, clr_idx: 6'h00, clr_done: 1'b0};
    end else begin
      q <= next_q;
    end
  end
endmodule : fiwb_wbuf

// ==== core/fiwb_wbuf_if.sv ====
// link between the controller and its 64-word write buffer
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface fiwb_wbuf_if;
  logic load;
  logic [5:0] load_idx;
  logic [15:0] load_data;
  logic [5:0] rd_idx;
  logic [15:0] rd_data;
  logic clr_start;
  logic clr_done;

  modport ctrl (output load, load_idx, load_data, rd_idx, clr_start,
                input rd_data, clr_done);
  modport store (input load, load_idx, load_data, rd_idx, clr_start,
                 output rd_data, clr_done);
endinterface : fiwb_wbuf_if

// ==== dv/fiwb_ctrl_asserts.sv ====
// port-level checks of the flash write-buffer controller
// assumes one clock domain and synchronous active-high srst
`timescale 1ns/1ps
module fiwb_ctrl_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register bus and stall
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic cpu_stall,
  // flash array
  input wire logic fl_req,
  input wire fiwb_pkg::fiwb_flop_t fl_op,
  input wire logic [13:0] fl_addr,
  input wire logic [15:0] fl_wdata,
  input wire logic fl_ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // one flash handshake ends at the acked edge
  sequence s_ack;
    fl_req && fl_ack;
  endsequence
  sequence s_read_ack;
    fl_req && fl_ack && fl_op == fiwb_pkg::FL_READ;
  endsequence
  // bus answer is a single-cycle strobe
  a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_rdata_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("readdata upper bits not zero");
  // flash request holds its qualifiers until acked
  a_req_hold: assert property (fl_req && !fl_ack |=> fl_req && $stable(fl_addr)
    && $stable(fl_op) && $stable(fl_wdata))
    else $error("flash request changed before ack");
  a_req_drop: assert property (s_ack |=> !fl_req)
    else $error("flash request not dropped after ack");
  a_read_end: assert property (s_read_ack |=> !cpu_stall ##0 !fl_req)
    else $error("stall not released after read");
  a_erase_page: assert property (fl_req && fl_op == fiwb_pkg::FL_ERASE
    |-> fl_addr[5:0] == 6'h00)
    else $error("erase address not page aligned");
  // processor held off while the array works
  a_stall_req: assert property (fl_req |-> cpu_stall)
    else $error("flash busy without stall");
  a_stall_bus: assert property (cpu_stall |-> avs_waitrequest)
    else $error("bus answered during stall");
endmodule : fiwb_ctrl_asserts

bind fiwb_ctrl fiwb_ctrl_asserts fiwb_ctrl_asserts_inst (.clk(clk), .srst(srst),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_stall(cpu_stall),
  .fl_req(fl_req), .fl_op(fl_op), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_ack(fl_ack));

// ==== dv/fiwb_flash_model.sv ====
// behavioural program flash array, 16K words, answering with random latency
// assumes requests hold until the one-cycle ack
`timescale 1ns/1ps
module fiwb_flash_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // request side
  input wire logic fl_req,
  input wire fiwb_pkg::fiwb_flop_t fl_op,
  input wire logic [13:0] fl_addr,
  input wire logic [15:0] fl_wdata,
  // answer side
  output logic fl_ack,
  output logic [15:0] fl_rdata
);
  logic [15:0] mem [0:16383];
  logic [1:0] wait_cnt;
  // known start contents, mirrored by the bench
  initial begin
    for (int i = 0; i < 16384; i++) mem[i] = 16'(i) ^ 16'hA5C3;
    fl_ack = 1'b0;
    fl_rdata = 16'h0000;
    wait_cnt = 2'h0;
  end
  // read data toggles every cycle except at a read answer, so stale sampling shows up
  always @(posedge clk) begin
    fl_ack <= 1'b0;
    fl_rdata <= ~fl_rdata;
    if (srst) begin
      wait_cnt <= 2'h0;
    end else if (fl_req && !fl_ack) begin
      if (wait_cnt == 2'h0) begin
        fl_ack <= 1'b1;
        wait_cnt <= 2'($urandom_range(0, 3));
        case (fl_op)
          fiwb_pkg::FL_READ: fl_rdata <= mem[fl_addr];
          fiwb_pkg::FL_ERASE: for (int j = 0; j < 64; j++)
            mem[{fl_addr[13:6], 6'(j)}] = 16'hFFFF;
          // bits only fall, so programming needs a prior erase
          default: mem[fl_addr] = mem[fl_addr] & fl_wdata;
        endcase
      end else begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule : fiwb_flash_model

// ==== dv/tb_fiwb_ctrl.sv ====
// self-checking bench of the flash write-buffer controller
// assumes the flash model and the bound checker beside it
`timescale 1ns/1ps
`include "fiwb_regs.svh"
module tb_fiwb_ctrl;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic wreq, stall, freq, fack;
  fiwb_pkg::fiwb_flop_t fop;
  logic [13:0] faddr;
  logic [15:0] fwd, read_start_bit, w;
  logic [7:0] v, me, mm;
  logic [7:0] q_e[$];
  logic [7:0] q_m[$];
  logic [15:0] wexp [0:63];
  logic [7:0] pat [0:5] = '{8'h34, 8'h12, 8'h78, 8'h56, 8'hBC, 8'h00};
  int n_fail = 0;
  int samples_checked = 0;
  int i;
  always #50 clk = ~clk;
  fiwb_ctrl #(.UNLOCK_CYCLES(20)) fiwb_ctrl_inst (.clk(clk), .srst(srst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hF),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .cpu_stall(stall), .fl_req(freq),
    .fl_op(fop), .fl_addr(faddr), .fl_wdata(fwd), .fl_ack(fack), .fl_rdata(read_start_bit));
  fiwb_flash_model fiwb_flash_model_inst (.clk(clk), .srst(srst), .fl_req(freq),
    .fl_op(fop), .fl_addr(faddr), .fl_wdata(fwd), .fl_ack(fack), .fl_rdata(read_start_bit));
  task chk8(input logic [7:0] g, input logic [7:0] e, input logic [7:0] m);
    samples_checked++;
    if ((g & m) !== (e & m)) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk8
  // watcher takes the oldest note at each read answer; mask 0 marks a poll
  always @(posedge clk) begin
    if (rd && wreq === 1'b0 && q_e.size() > 0) begin
      me = q_e.pop_front();
      mm = q_m.pop_front();
      if (mm != 8'h00) chk8(rdat[7:0], me, mm);
    end
  end
  // request held until waitrequest is seen low at an edge
  task bus_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= {24'h000000, d};
    wr <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    wr <= 1'b0;
  endtask : bus_wr
  task bus_rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
    q_e.push_back(e);
    q_m.push_back(m);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    v = rdat[7:0];
    rd <= 1'b0;
  endtask : bus_rd
  task poll(input logic [5:0] a, input logic [7:0] bm);
    for (int k = 0; k < 200; k++) begin
      bus_rd(a, 8'h00, 8'h00);
      if ((v & bm) == 8'h00) break;
    end
  endtask : poll
  task set_addr(input logic [13:0] a);
    bus_wr(`FIWB_OFS_ADDR_HI, {2'b00, a[13:8]});
    bus_wr(`FIWB_OFS_ADDR_LO, a[7:0]);
  endtask : set_addr
  task load(input logic [15:0] d);
    bus_wr(`FIWB_OFS_D0_LO, d[7:0]);
    bus_wr(`FIWB_OFS_D0_HI, d[15:8]);
  endtask : load
  task rd_word(input logic [13:0] a, input logic [15:0] e);
    set_addr(a);
    bus_wr(`FIWB_OFS_CTRL, 8'hB2);
    bus_wr(`FIWB_OFS_CTRL, 8'hB3);
    bus_rd(`FIWB_OFS_CTRL, 8'hB2, 8'h7F);
    bus_rd(`FIWB_OFS_D0_LO, e[7:0], 8'hFF);
    bus_rd(`FIWB_OFS_D0_HI, e[15:8], 8'hFF);
  endtask : rd_word
  task test_done;
    $display("compares %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  // watchdog well beyond the expected run
  initial begin
    #(60000 * 100);
    n_fail++;
    test_done();
  end
  // main sequence
  initial begin
    void'($urandom(32'h3D6986BB));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i <= 'h30; i += 4) bus_rd(6'(i), 8'h00, 8'hFF);
    load(16'h1111);
    bus_rd(`FIWB_OFS_ADDR_LO, 8'h00, 8'hFF);
    bus_wr(`FIWB_OFS_CTRL, 8'h80);
    bus_rd(`FIWB_OFS_CTRL, 8'h00, 8'hFF);
    // wrong last pattern, window must run out
    for (i = 0; i < 6; i++) bus_wr(6'(`FIWB_OFS_D1_LO + 4 * i), pat[i]);
    bus_wr(`FIWB_OFS_CTRL, 8'h68);
    bus_rd(`FIWB_OFS_CTRL, 8'h68, 8'hFF);
    poll(`FIWB_OFS_CTRL, 8'h08);
    bus_rd(`FIWB_OFS_CTRL, 8'h60, 8'hFF);
    bus_wr(`FIWB_OFS_D3_HI, 8'h9A);
    bus_wr(`FIWB_OFS_CTRL, 8'h68);
    poll(`FIWB_OFS_CTRL, 8'h08);
    bus_rd(`FIWB_OFS_CTRL, 8'hE0, 8'hFF);
    // erase pages 5, 6, 7 from unaligned addresses
    for (i = 5; i < 8; i++) begin
      set_addr(14'(i * 64 + 42));
      bus_wr(`FIWB_OFS_CTRL, 8'h94);
      bus_rd(`FIWB_OFS_CTRL, 8'h90, 8'hFF);
    end
    rd_word(14'h01A5, 16'hFFFF);
    rd_word(14'h0200, 16'h0200 ^ 16'hA5C3);
    bus_wr(`FIWB_OFS_BUFCTL, 8'h01);
    bus_rd(`FIWB_OFS_BUFCTL, 8'h01, 8'hFF);
    poll(`FIWB_OFS_BUFCTL, 8'h01);
    bus_rd(`FIWB_OFS_BUFCTL, 8'h00, 8'hFF);
    // 66 loads, the last three land on word 63
    set_addr(14'h0140);
    for (i = 0; i < 66; i++) begin
      w = 16'($urandom);
      wexp[i > 63 ? 63 : i] = w;
      load(w);
      if (i == 0) bus_rd(`FIWB_OFS_ADDR_LO, 8'h41, 8'hFF);
    end
    bus_rd(`FIWB_OFS_ADDR_LO, 8'h7F, 8'hFF);
    bus_rd(`FIWB_OFS_ADDR_HI, 8'h01, 8'hFF);
    bus_wr(`FIWB_OFS_CTRL, 8'h84);
    bus_rd(`FIWB_OFS_CTRL, 8'h80, 8'hFF);
    for (int k = 0; k < 4; k++) begin
      i = (k == 3) ? 63 : $urandom_range(0, 62);
      rd_word(14'(14'h0140 + i), wexp[i]);
    end
    // one word into a fresh page; stale words must not follow
    set_addr(14'h01C0);
    bus_wr(`FIWB_OFS_BUFCTL, 8'h01);
    poll(`FIWB_OFS_BUFCTL, 8'h01);
    load(16'h00FF);
    bus_wr(`FIWB_OFS_CTRL, 8'h84);
    rd_word(14'h01C1, 16'hFFFF);
    rd_word(14'h01C0, 16'h00FF);
    set_addr(14'h01C1);
    bus_wr(`FIWB_OFS_CTRL, 8'hB1);
    bus_rd(`FIWB_OFS_CTRL, 8'hB0, 8'hFF);
    bus_rd(`FIWB_OFS_D0_HI, 8'h00, 8'hFF);
    bus_wr(6'h04, 8'hFF);
    bus_rd(6'h04, 8'h00, 8'hFF);
    bus_wr(`FIWB_OFS_CTRL, 8'h00);
    bus_rd(`FIWB_OFS_CTRL, 8'h00, 8'hFF);
    test_done();
  end
endmodule : tb_fiwb_ctrl
